// ---- pwm_wave_pkg.sv ----
// constants, field layouts and enumerations shared by the pwm wave counter files
// assumes a single 25 MHz clock domain and a synchronous active-high reset
`default_nettype none

package pwm_wave_pkg;

  // core clock, 40 ns period
  localparam int CLK_PERIOD_NS = 40;

  // counter and channel geometry
  localparam int CNT_W = 15;
  localparam int NUM_CH = 4;
  localparam int WORD_W = 16;
  localparam int POL_BIT = 15;
  localparam int CMP_LSB = 0;
  localparam int LAYOUT_A_CH = 3;
  localparam int LAYOUT_A_TOP_WORD = 3;

  // pwm clock divider: 2**sel, sel 0..7
  localparam int PRESC_W = 3;
  localparam int DIV_W = 7;

  // values after reset
  localparam logic [CNT_W-1:0] COUNTER_RST = 15'h0000;
  localparam logic [CNT_W-1:0] TOP_RST = 15'h0000;
  localparam logic [CNT_W-1:0] CMP_RST = 15'h0000;
  localparam logic [DIV_W-1:0] DIV_RST = 7'h00;

  // polarity encoding of the parameter word msb
  localparam logic POL_HIGH_FIRST = 1'b0;

  // how decoder words map onto the compare channels
  typedef enum logic [1:0] {
    LOAD_COMMON = 2'h0,
    LOAD_GROUPED = 2'h1,
    LOAD_INDIVIDUAL = 2'h2,
    LOAD_LAYOUT_A = 2'h3
  } load_layout_e;

  // run state of the wave counter, one-hot
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_RUN = 2'b10
  } run_state_e;

endpackage

`default_nettype wire

// ---- pwm_prescaler.sv ----
// divider producing the one-cycle pwm clock enable
// assumes select is steady while running; restarts from zero when idle
`default_nettype none

module pwm_prescaler (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic run_i,
  input wire logic [pwm_wave_pkg::PRESC_W-1:0] div_sel_i,
  output logic tick_o
);

  typedef struct packed {
    logic [pwm_wave_pkg::DIV_W-1:0] cnt;
  } presc_s;

  presc_s st_ff;
  presc_s nxt_st;
  logic [pwm_wave_pkg::DIV_W-1:0] mask;

  // tick whenever the low sel bits of the count are all ones
  always_comb begin
    nxt_st = st_ff;
    mask = pwm_wave_pkg::DIV_W'((8'h01 << div_sel_i) - 8'h01);
    tick_o = run_i && ((st_ff.cnt & mask) == mask);
    if (!run_i) begin
      nxt_st.cnt = pwm_wave_pkg::DIV_RST;
    end else begin
      nxt_st.cnt = st_ff.cnt + 7'h01;
    end
  end

  // count register
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      st_ff.cnt <= pwm_wave_pkg::DIV_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

endmodule

`default_nettype wire

// ---- pwm_wave_counter.sv ----
// four-channel pwm wave counter with a shared 15-bit counter
// assumes decoder words, layout and software top arrive on the clk_i domain
//
// Function
// - one shared 15-bit counter feeds four compare channels, same period
// - each channel output drives its assigned gpio pin with its layout_a
// - direction setting selects up-only or up-and-down counting
// - period set by top value and selected pwm clock divider
// - top below compare gives no edges; high-first output stays high
// - compare registers are internal, loaded only by the decoder
// - software top may be written any time without upsetting layout_a
// - in layout a the top value comes from ram, not software
// - other layouts sample software top at launch and at each load
// - up mode wraps to zero at top and outputs toggle there
// - high-first: compare zero holds low, compare equal to top holds high in up mode
// - up counting gives edge-aligned pulses across channels
// - up period is divided clock times top, step one divided clock
// - up-down counts back to zero, output toggles on second match
// - up-down counting gives center-aligned pulses
// - up-down period is twice top, step two divided clocks
// - polarity, duty, period update from memory glitch-free per period
// - word msb is polarity, low fifteen bits the compare value
// - layout a uses channels 0-2; fourth word carries the top value
`default_nettype none

module pwm_wave_counter (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic enable_i,
  input wire logic count_up_then_down_i,
  input wire logic [pwm_wave_pkg::PRESC_W-1:0] div_sel_i,
  input wire logic [pwm_wave_pkg::CNT_W-1:0] period_top_value_i,
  input wire logic sequence_launch_task_i,
  input wire logic stop_task_i,
  input wire logic load_valid_i,
  input wire logic [1:0] load_layout_i,
  input wire logic [pwm_wave_pkg::NUM_CH-1:0][pwm_wave_pkg::WORD_W-1:0] load_words_i,
  output logic load_ready_o,
  output logic [pwm_wave_pkg::NUM_CH-1:0] pwm_out_o,
  output logic running_o,
  output logic period_end_o,
  output logic value_applied_o
);

  localparam int N = pwm_wave_pkg::NUM_CH;
  localparam int W = pwm_wave_pkg::CNT_W;

  // whole state of the block
  typedef struct packed {
    pwm_wave_pkg::run_state_e run;
    logic [W-1:0] counter;
    logic down;
    logic [W-1:0] top;
    logic [N-1:0][W-1:0] cmp;
    logic [N-1:0] pol;
    pwm_wave_pkg::load_layout_e layout;
    logic pend_valid;
    logic [N-1:0][W-1:0] pend_cmp;
    logic [N-1:0] pend_pol;
    logic [W-1:0] pend_top;
    pwm_wave_pkg::load_layout_e pend_layout;
    logic stop_pend;
    logic [N-1:0] out;
    logic period_end;
    logic applied;
    logic busy;
    logic ready;
  } state_s;

  state_s st_ff;
  state_s nxt_st;

  logic tick;
  logic running;
  logic at_end;
  logic boundary;
  logic apply;
  logic take;
  logic [N-1:0] match_lo;
  pwm_wave_pkg::load_layout_e in_layout;
  logic [N-1:0][pwm_wave_pkg::WORD_W-1:0] route;

  assign running = (st_ff.run == pwm_wave_pkg::ST_RUN);
  assign in_layout = pwm_wave_pkg::load_layout_e'(load_layout_i);

  // pwm clock enable from the divider
  pwm_prescaler u_presc (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .run_i(running && enable_i),
    .div_sel_i(div_sel_i),
    .tick_o(tick)
  );

  // end of period detect for both counting directions
  always_comb begin
    if (!count_up_then_down_i) begin
      at_end = (st_ff.top == 15'h0000) || (st_ff.counter >= (st_ff.top - 15'h0001));
    end else if (st_ff.down) begin
      at_end = (st_ff.counter <= 15'h0001);
    end else begin
      at_end = (st_ff.top <= 15'h0001) && (st_ff.counter >= st_ff.top);
    end
    boundary = running && tick && at_end;
    apply = st_ff.pend_valid && (!running || boundary);
    take = load_valid_i && !st_ff.pend_valid;
  end

  // decoder word routing onto channels by layout
  always_comb begin
    route = load_words_i;
    case (in_layout)
      pwm_wave_pkg::LOAD_COMMON: begin
        route = {N{load_words_i[0]}};
      end
      pwm_wave_pkg::LOAD_GROUPED: begin
        route = {load_words_i[1], load_words_i[1], load_words_i[0], load_words_i[0]};
      end
      pwm_wave_pkg::LOAD_LAYOUT_A: begin
        route = {16'h0000, load_words_i[2], load_words_i[1], load_words_i[0]};
      end
      pwm_wave_pkg::LOAD_INDIVIDUAL: begin
        route = load_words_i;
      end
      default: begin
        route = load_words_i;
      end
    endcase
  end

  // next-state logic
  always_comb begin
    nxt_st = st_ff;
    nxt_st.period_end = 1'b0;
    nxt_st.applied = 1'b0;

    // hold one decoder load until the next boundary
    if (take) begin
      nxt_st.pend_valid = 1'b1;
      nxt_st.pend_layout = in_layout;
      for (int i = 0; i < N; i++) begin
        nxt_st.pend_pol[i] = route[i][pwm_wave_pkg::POL_BIT];
        nxt_st.pend_cmp[i] = route[i][pwm_wave_pkg::CMP_LSB +: W];
      end
      nxt_st.pend_top = load_words_i[pwm_wave_pkg::LAYOUT_A_TOP_WORD][W-1:0];
    end

    // launch samples the software top outside layout a
    if (sequence_launch_task_i && (in_layout != pwm_wave_pkg::LOAD_LAYOUT_A)) begin
      nxt_st.top = period_top_value_i;
    end
    if (stop_task_i && running) begin
      nxt_st.stop_pend = 1'b1;
    end

    // counter stepping on the divided clock
    if (running && tick) begin
      if (!count_up_then_down_i) begin
        nxt_st.down = 1'b0;
        nxt_st.counter = at_end ? 15'h0000 : st_ff.counter + 15'h0001;
      end else if (at_end) begin
        nxt_st.down = 1'b0;
        nxt_st.counter = 15'h0000;
      end else if (!st_ff.down) begin
        if (st_ff.counter >= st_ff.top) begin
          nxt_st.down = 1'b1;
          nxt_st.counter = st_ff.top - 15'h0001;
        end else begin
          nxt_st.counter = st_ff.counter + 15'h0001;
        end
      end else begin
        nxt_st.counter = st_ff.counter - 15'h0001;
      end
    end
    if (boundary) begin
      nxt_st.period_end = 1'b1;
    end

    // apply pending values at the period boundary or to start
    if (apply) begin
      nxt_st.cmp = st_ff.pend_cmp;
      nxt_st.pol = st_ff.pend_pol;
      nxt_st.layout = st_ff.pend_layout;
      nxt_st.pend_valid = take;
      nxt_st.applied = 1'b1;
      if (st_ff.pend_layout == pwm_wave_pkg::LOAD_LAYOUT_A) begin
        nxt_st.top = st_ff.pend_top;
      end else begin
        nxt_st.top = period_top_value_i;
      end
      if (!running && enable_i) begin
        nxt_st.run = pwm_wave_pkg::ST_RUN;
        nxt_st.counter = pwm_wave_pkg::COUNTER_RST;
        nxt_st.down = 1'b0;
      end
    end

    // stop at the end of the running period, or at once when enable_i drops
    case (st_ff.run)
      pwm_wave_pkg::ST_IDLE: begin
        nxt_st.stop_pend = 1'b0;
      end
      pwm_wave_pkg::ST_RUN: begin
        if (!enable_i || (boundary && (st_ff.stop_pend || stop_task_i))) begin
          nxt_st.run = pwm_wave_pkg::ST_IDLE;
          nxt_st.stop_pend = 1'b0;
        end
      end
      default: begin
        nxt_st.run = pwm_wave_pkg::ST_IDLE;
      end
    endcase
    if (nxt_st.run != pwm_wave_pkg::ST_RUN) begin
      nxt_st.counter = pwm_wave_pkg::COUNTER_RST;
      nxt_st.down = 1'b0;
    end

    // channel outputs from the next counter and compare values
    for (int i = 0; i < N; i++) begin
      match_lo[i] = nxt_st.counter < nxt_st.cmp[i];
      if (nxt_st.run != pwm_wave_pkg::ST_RUN) begin
        nxt_st.out[i] = 1'b0;
      end else if ((nxt_st.layout == pwm_wave_pkg::LOAD_LAYOUT_A) &&
                   (i == pwm_wave_pkg::LAYOUT_A_CH)) begin
        nxt_st.out[i] = 1'b0;
      end else if (nxt_st.pol[i] == pwm_wave_pkg::POL_HIGH_FIRST) begin
        nxt_st.out[i] = match_lo[i];
      end else begin
        nxt_st.out[i] = !match_lo[i];
      end
    end

    // registered copies for the status outputs
    nxt_st.busy = (nxt_st.run == pwm_wave_pkg::ST_RUN);
    nxt_st.ready = !nxt_st.pend_valid;
  end

  // state register
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      st_ff <= '0;
      st_ff.run <= pwm_wave_pkg::ST_IDLE;
      st_ff.counter <= pwm_wave_pkg::COUNTER_RST;
      st_ff.top <= pwm_wave_pkg::TOP_RST;
      st_ff.cmp <= {N{pwm_wave_pkg::CMP_RST}};
      st_ff.layout <= pwm_wave_pkg::LOAD_COMMON;
      st_ff.pend_layout <= pwm_wave_pkg::LOAD_COMMON;
      st_ff.ready <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // outputs straight from the state register
  assign pwm_out_o = st_ff.out;
  assign running_o = st_ff.busy;
  assign period_end_o = st_ff.period_end;
  assign value_applied_o = st_ff.applied;
  assign load_ready_o = st_ff.ready;

  a_idle_counter_zero: assert property (@(posedge clk_i) disable iff (reset_i)
    !running |-> (st_ff.counter == 15'h0000 && pwm_out_o == 4'h0))
    else $error("counter moved while idle");

  a_up_wrap_zero: assert property (@(posedge clk_i) disable iff (reset_i)
    (running && tick && !count_up_then_down_i && at_end && enable_i)
      |=> (st_ff.counter == 15'h0000 && period_end_o))
    else $error("up counter did not wrap at top");

  a_zero_cmp_low: assert property (@(posedge clk_i) disable iff (reset_i)
    (running && st_ff.cmp[0] == 15'h0000 && st_ff.pol[0] == pwm_wave_pkg::POL_HIGH_FIRST)
      |-> !pwm_out_o[0])
    else $error("zero compare not held low");

  a_top_below_cmp: assert property (@(posedge clk_i) disable iff (reset_i)
    (running && st_ff.cmp[1] > st_ff.top && st_ff.pol[1] == pwm_wave_pkg::POL_HIGH_FIRST &&
     st_ff.layout != pwm_wave_pkg::LOAD_LAYOUT_A) |-> pwm_out_o[1])
    else $error("output not held high with compare above top");

  a_updown_turn: assert property (@(posedge clk_i) disable iff (reset_i)
    (running && enable_i && tick && count_up_then_down_i && !st_ff.down &&
     st_ff.top > 15'h0001 && st_ff.counter == st_ff.top)
      |=> (st_ff.down && st_ff.counter == $past(st_ff.top) - 15'h0001))
    else $error("up-down counter did not turn at top");

  a_cmp_at_boundary: assert property (@(posedge clk_i) disable iff (reset_i)
    (st_ff.cmp != $past(st_ff.cmp)) |-> $past(apply))
    else $error("compare changed away from a boundary");

  a_layout_a_top: assert property (@(posedge clk_i) disable iff (reset_i)
    (apply && st_ff.pend_layout == pwm_wave_pkg::LOAD_LAYOUT_A)
      |=> st_ff.top == $past(st_ff.pend_top))
    else $error("layout a top not taken from ram");

  a_launch_top: assert property (@(posedge clk_i) disable iff (reset_i)
    (sequence_launch_task_i && !apply && in_layout != pwm_wave_pkg::LOAD_LAYOUT_A)
      |=> st_ff.top == $past(period_top_value_i))
    else $error("software top not sampled at launch");

  a_layout_a_ch3: assert property (@(posedge clk_i) disable iff (reset_i)
    (st_ff.layout == pwm_wave_pkg::LOAD_LAYOUT_A) |-> !pwm_out_o[3])
    else $error("channel 3 active in layout a");

  // counter stepping, decoder hand-over and idle checks
  a_load_ready_drop: assert property (@(posedge clk_i) disable iff (reset_i)
    (load_valid_i && load_ready_o) |=> !load_ready_o)
    else $error("ready stayed high after a take");

  a_up_step: assert property (@(posedge clk_i) disable iff (reset_i)
    (running && enable_i && tick && !count_up_then_down_i && !at_end)
      |=> st_ff.counter == $past(st_ff.counter) + 15'h0001)
    else $error("up counter did not step by one");

  a_tick_hold: assert property (@(posedge clk_i) disable iff (reset_i)
    (running && enable_i && !tick) |=> st_ff.counter == $past(st_ff.counter))
    else $error("counter moved without a divided tick");

  a_updown_rise: assert property (@(posedge clk_i) disable iff (reset_i)
    (running && enable_i && tick && count_up_then_down_i && !st_ff.down &&
     st_ff.counter < st_ff.top)
      |=> (!st_ff.down && st_ff.counter == $past(st_ff.counter) + 15'h0001))
    else $error("up-down counter did not rise by one");

  a_updown_bottom: assert property (@(posedge clk_i) disable iff (reset_i)
    (running && enable_i && tick && count_up_then_down_i && st_ff.down &&
     st_ff.counter <= 15'h0001)
      |=> (st_ff.counter == 15'h0000 && !st_ff.down && period_end_o))
    else $error("up-down counter did not end its period at zero");

  a_apply_on_end: assert property (@(posedge clk_i) disable iff (reset_i)
    (value_applied_o && $past(running)) |-> period_end_o)
    else $error("values applied inside a running period");

  a_pend_hold: assert property (@(posedge clk_i) disable iff (reset_i)
    (running && enable_i && st_ff.pend_valid && !boundary) |=> st_ff.pend_valid)
    else $error("pending values taken before the period end");

  a_disable_idle: assert property (@(posedge clk_i) disable iff (reset_i)
    (running && !enable_i) |=> !running_o)
    else $error("block kept running while disabled");

endmodule

`default_nettype wire

// ---- ram_decoder_model.sv ----
// behavioural ram parameter decoder that feeds words to the wave counter
// assumes the bench pulses offer_i once per load and waits for it to be taken
`default_nettype none

module ram_decoder_model (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic offer_i,
  input wire logic [3:0] hold_i,
  input wire logic [1:0] lay_i,
  input wire logic [pwm_wave_pkg::NUM_CH-1:0][pwm_wave_pkg::WORD_W-1:0] words_i,
  input wire logic load_ready_i,
  output logic load_valid_o,
  output logic [1:0] load_layout_o,
  output logic [pwm_wave_pkg::NUM_CH-1:0][pwm_wave_pkg::WORD_W-1:0] load_words_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic armed;
  logic [3:0] hold;

  // offer after a hold-off, keep it until taken, then scramble the released bus
  always @(posedge clk_i) begin
    if (reset_i) begin
      load_valid_o <= 1'b0;
      load_layout_o <= 2'h0;
      load_words_o <= '0;
      armed <= 1'b0;
      hold <= 4'h0;
    end else if (load_valid_o && load_ready_i) begin
      load_valid_o <= 1'b0;
      load_layout_o <= ~load_layout_o;
      load_words_o <= ~load_words_o;
    end else if (offer_i) begin
      armed <= 1'b1;
      hold <= hold_i;
    end else if (armed && hold != 4'h0) begin
      hold <= hold - 4'h1;
    end else if (armed) begin
      armed <= 1'b0;
      load_valid_o <= 1'b1;
      load_layout_o <= lay_i;
      load_words_o <= words_i; // msb polarity, low bits compare
    end
  end
endmodule

`default_nettype wire

// ---- tb_pwm_wave_counter.sv ----
// self-checking bench for the pwm wave counter with a decoder model
// assumes 25 MHz clk_i, inputs driven on the falling edge
`default_nettype none

module tb_pwm_wave_counter;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {
    logic [1:0] lay;
    logic ud;
    logic [2:0] sel;
    logic [14:0] top;
    logic [15:0] w0, w1, w3, per, h0, h3;
  } row_s;
  logic clk_i, reset_i, enable, ud, launch, stop, offer, load_valid, load_ready;
  logic running, period_end, applied;
  logic [2:0] sel;
  logic [14:0] top;
  logic [3:0] hold;
  logic [1:0] lay, load_layout;
  logic [3:0][15:0] words, load_words;
  logic [3:0] pwm_out;
  logic [15:0] per, h0, h3;
  int fail_count, cmp_count, cyc;
  // layout, mode, divider, top, words, then period and high cycles of ch0 and ch3
  row_s rows [7] = '{
    '{2'h0, 1'h0, 3'h0, 15'h4, 16'h1, 16'h0, 16'h0, 16'h4, 16'h1, 16'h1},
    '{2'h2, 1'h0, 3'h0, 15'h4, 16'h0, 16'h2, 16'h4, 16'h4, 16'h0, 16'h4},
    '{2'h1, 1'h0, 3'h0, 15'h3, 16'h5, 16'h1, 16'h0, 16'h3, 16'h3, 16'h1},
    '{2'h2, 1'h1, 3'h1, 15'h4, 16'h2, 16'h0, 16'h1, 16'h10, 16'h6, 16'h2},
    '{2'h0, 1'h0, 3'h2, 15'h3, 16'h1, 16'h0, 16'h0, 16'hC, 16'h4, 16'h4},
    '{2'h2, 1'h0, 3'h0, 15'h4, 16'h8001, 16'h0, 16'h8000, 16'h4, 16'h3, 16'h4},
    '{2'h3, 1'h0, 3'h0, 15'h2, 16'h1, 16'h0, 16'h5, 16'h5, 16'h1, 16'h0}
  };

  pwm_wave_counter u_pwm_wave_counter (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .enable_i(enable),
    .count_up_then_down_i(ud),
    .div_sel_i(sel),
    .period_top_value_i(top),
    .sequence_launch_task_i(launch),
    .stop_task_i(stop),
    .load_valid_i(load_valid),
    .load_layout_i(load_layout),
    .load_words_i(load_words),
    .load_ready_o(load_ready),
    .pwm_out_o(pwm_out),
    .running_o(running),
    .period_end_o(period_end),
    .value_applied_o(applied)
  );

  ram_decoder_model u_ram_decoder_model (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .offer_i(offer),
    .hold_i(hold),
    .lay_i(lay),
    .words_i(words),
    .load_ready_i(load_ready),
    .load_valid_o(load_valid),
    .load_layout_o(load_layout),
    .load_words_o(load_words)
  );

  // free-running 40 ns clock
  initial clk_i = 1'b0;
  always #20 clk_i = ~clk_i;

  // verdict and end of run
  task automatic wrap_up();
    if (fail_count == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // compare seen against expected
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %0h, seen %0h", what, exp, seen);
    end
  endtask

  // hand words to the decoder model and wait for them to be applied
  task automatic load(input logic [1:0] l, input logic [3:0][15:0] w, input logic [3:0] h);
    int n;
    @(negedge clk_i);
    lay <= l;
    words <= w;
    hold <= h;
    offer <= 1'b1;
    @(negedge clk_i);
    offer <= 1'b0;
    n = 0;
    while (applied !== 1'b1 && n < 200) begin
      @(negedge clk_i);
      n++;
    end
    check("value applied", {15'h0, applied}, 16'h1);
  endtask

  // one full period between two boundary pulses, counting high cycles
  task automatic measure(output logic [15:0] p, output logic [15:0] a, output logic [15:0] b);
    int n;
    n = 0;
    do begin
      @(negedge clk_i);
      n++;
    end while (period_end !== 1'b1 && n < 100);
    p = 16'h0;
    a = 16'h0;
    b = 16'h0;
    do begin
      @(negedge clk_i);
      p++;
      a += {15'h0, pwm_out[0]};
      b += {15'h0, pwm_out[3]};
    end while (period_end !== 1'b1 && p < 16'h64);
  endtask

  // hang guard
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      wrap_up();
    end
  end

  // main sequence
  initial begin
    {enable, ud, launch, stop, offer, sel, top, hold, lay, words} = '0;
    reset_i = 1'b1;
    fail_count = 0;
    cmp_count = 0;
    repeat (3) @(negedge clk_i);
    reset_i <= 1'b0;
    @(negedge clk_i);
    check("ready after reset", {15'h0, load_ready}, 16'h1);
    check("out after reset", {12'h0, pwm_out}, 16'h0);
    foreach (rows[i]) begin
      @(negedge clk_i);
      enable <= 1'b0;
      ud <= rows[i].ud;
      sel <= rows[i].sel;
      top <= rows[i].top;
      repeat (2) @(negedge clk_i);
      check("idle out", {11'h0, running, pwm_out}, 16'h0);
      enable <= 1'b1;
      load(rows[i].lay, {rows[i].w3, rows[i].w1, rows[i].w1, rows[i].w0}, 4'h0);
      measure(per, h0, h3);
      check("period", per, rows[i].per);
      check("ch0 high", h0, rows[i].h0);
      check("ch3 high", h3, rows[i].h3);
    end
    // software top changed mid-run only counts after the next load
    @(negedge clk_i);
    enable <= 1'b0;
    sel <= 3'h0;
    top <= 15'h4;
    @(negedge clk_i);
    launch <= 1'b1;
    @(negedge clk_i);
    launch <= 1'b0;
    enable <= 1'b1;
    load(2'h0, {4{16'h0001}}, 4'h0);
    @(negedge clk_i);
    top <= 15'h6;
    measure(per, h0, h3);
    check("period before reload", per, 16'h4);
    load(2'h0, {4{16'h0002}}, 4'h5);
    measure(per, h0, h3);
    check("period after reload", per, 16'h6);
    check("duty after reload", h0, 16'h2);
    // stop waits for the period end, then the counter rests
    @(negedge clk_i);
    stop <= 1'b1;
    @(negedge clk_i);
    stop <= 1'b0;
    check("running after stop", {15'h0, running}, 16'h1);
    repeat (10) @(negedge clk_i);
    check("stopped", {11'h0, running, pwm_out}, 16'h0);
    wrap_up();
  end
endmodule

`default_nettype wire
